// [pkg/ceac_pkg.sv]
// Constants for the configuration memory access control block.
// Assumes a single 250 MHz core clock; all users write ceac_pkg::name.
package ceac_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Address map of operating and nonvolatile locations.
    localparam logic [7:0] OP_LO = 8'h0a;
    localparam logic [7:0] OP_HI = 8'h40;
    localparam logic [7:0] OP_EVCTL = 8'h90;
    localparam logic [7:0] NV_LO = 8'haa;
    localparam logic [7:0] NV_HI = 8'he0;
    localparam logic [7:0] NV_EVCTL = 8'hf0;
    localparam logic [7:0] NV_USER_LO = 8'hf1;
    localparam logic [7:0] NV_USER_HI = 8'hf7;

    // Storage sizes and array indices.
    localparam int NV_N = 63;
    localparam int OP_N = 56;
    localparam logic [5:0] EVCTL_IDX = 6'h37;
    localparam logic [5:0] USER_IDX = 6'h38;
    localparam int IDX_W = 6;

    // Data values.
    localparam logic [7:0] READ_BLOCKED = 8'hff;
    localparam logic [7:0] NV_ERASED = 8'hff;
    localparam logic [7:0] UNMAPPED_RD = 8'h00;
    localparam logic [7:0] OP_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Timing: times in microseconds, counts in core clock cycles.
    localparam int CLK_MHZ = 250;
    localparam int WRITE_TIME_US = 2200;
    localparam int COPY_TIME_US = 1300;
    localparam int WRITE_CYC = WRITE_TIME_US * CLK_MHZ;
    localparam int COPY_CYC = COPY_TIME_US * CLK_MHZ;
    localparam int CNT_W = 20;

    // Sequencer states.
    typedef enum logic [2:0] {
        CEAC_ST_COPY = 3'b001,
        CEAC_ST_IDLE = 3'b010,
        CEAC_ST_BUSY = 3'b100
    } ceac_state_e;

endpackage : ceac_pkg

// [rtl/ceac_top.sv]
// Access control for the on-chip nonvolatile configuration memory.
// Assumes a two-wire slave on clk that presents one byte access per request
// and takes the ACK/NACK and read data one cycle later; rst_n is lockout.
`timescale 1ns/1ps

// Operation
// - Write takes 2.2 ms, busy flag high throughout.
// - NACK memory writes while write pending.
// - Memory reads return 0xFF while pending.
// - Event record control write refused while pending.
// - Volatile registers served normally while pending.
// - Write end clears busy, sets written flag.
// - Written rising edge with enable raises alert.
// - Lockout exit or restart copies memory, 1.3 ms.
// - During copy every command is NACKed.
// - 0x0A-0x40 map 0xAA-0xE0; 0x90 maps 0xF0.
// - Seven user bytes, free general storage.
// - Write-protect high NACKs memory writes, no change.
// - Event record writes pass protect unless broadcast.
// - Memory reads succeed regardless of protect.
// - Live protect level readable as status.
// - Lock ignores protect, refuses writes, stops recording.
// - Locked flag reads one exactly when locked.
// - Control write also writes backup, memory busy, unless protected or locked.
module ceac_top #(
    parameter int WRITE_CYC = ceac_pkg::WRITE_CYC,
    parameter int COPY_CYC = ceac_pkg::COPY_CYC
) (
    // Clock and lockout reset.
    input wire logic clk,
    input wire logic rst_n,
    // Byte access request from the two-wire slave.
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [7:0] req_addr,
    input wire logic [7:0] req_wdata,
    // Answer to the access.
    output logic rsp_valid,
    output logic rsp_ack,
    output logic [7:0] rsp_rdata,
    // Pins and straps.
    input wire logic wp_pin,
    input wire logic nvm_lock_strap,
    input wire logic broadcast_mode,
    // Control bits.
    input wire logic restart_cmd,
    input wire logic evlog_req,
    input wire logic written_alert_en,
    input wire logic written_clr,
    input wire logic alert_clr,
    // Status bits.
    output logic nvm_busy,
    output logic copy_active,
    output logic nvm_written,
    output logic alert_raised,
    output logic alert_n,
    output logic wp_status,
    output logic nvm_locked_flag
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.
    ceac_pkg::ceac_state_e state_reg;
    ceac_pkg::ceac_state_e state_next;
    logic [ceac_pkg::CNT_W-1:0] cnt_reg;
    logic [ceac_pkg::CNT_W-1:0] cnt_next;
    // Nonvolatile storage is never cleared by lockout; it starts as an erased array.
    logic [7:0] nv_mem [ceac_pkg::NV_N] = '{default: ceac_pkg::NV_ERASED};
    logic [7:0] op_mem [ceac_pkg::OP_N];
    logic wp_s1_reg;
    logic wp_s2_reg;
    logic wp_s3_reg;
    logic nv_hit;
    logic op_hit;
    logic ev_hit;
    logic [ceac_pkg::IDX_W-1:0] nv_idx;
    logic [ceac_pkg::IDX_W-1:0] op_idx;
    logic copying;
    logic busy;
    logic acc;
    logic wr_block;
    logic wr_nv_ok;
    logic wr_ev_ok;
    logic backup_wr;
    logic ev_ok;
    logic nv_start;
    logic copy_end;
    logic write_end;
    logic written_next;
    logic alert_next;

    ////////////////////////////////////////////////////////////////////////
    // Address decode for nonvolatile and operating locations.
    always_comb begin
        nv_hit = 1'b0;
        op_hit = 1'b0;
        nv_idx = '0;
        op_idx = '0;
        if (req_addr >= ceac_pkg::NV_LO && req_addr <= ceac_pkg::NV_HI) begin
            nv_hit = 1'b1;
            nv_idx = 6'(req_addr - ceac_pkg::NV_LO);
        end else if (req_addr == ceac_pkg::NV_EVCTL) begin
            nv_hit = 1'b1;
            nv_idx = ceac_pkg::EVCTL_IDX;
        end else if (req_addr >= ceac_pkg::NV_USER_LO && req_addr <= ceac_pkg::NV_USER_HI) begin
            nv_hit = 1'b1;
            nv_idx = 6'(ceac_pkg::USER_IDX + 6'(req_addr - ceac_pkg::NV_USER_LO));
        end
        if (req_addr >= ceac_pkg::OP_LO && req_addr <= ceac_pkg::OP_HI) begin
            op_hit = 1'b1;
            op_idx = 6'(req_addr - ceac_pkg::OP_LO);
        end else if (req_addr == ceac_pkg::OP_EVCTL) begin
            op_hit = 1'b1;
            op_idx = ceac_pkg::EVCTL_IDX;
        end
    end

    assign ev_hit = (req_addr == ceac_pkg::OP_EVCTL);

    ////////////////////////////////////////////////////////////////////////
    // Write-protect pin synchroniser; the level moves once stages two and three agree.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_s1_reg <= 1'b0;
            wp_s2_reg <= 1'b0;
            wp_s3_reg <= 1'b0;
            wp_status <= 1'b0;
        end else begin
            wp_s1_reg <= wp_pin;
            wp_s2_reg <= wp_s1_reg;
            wp_s3_reg <= wp_s2_reg;
            if (wp_s2_reg == wp_s3_reg) begin
                wp_status <= wp_s3_reg;
            end
        end
    end

    // Lock strap is sampled every cycle after release; it is factory fixed.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nvm_locked_flag <= 1'b0;
        end else begin
            nvm_locked_flag <= nvm_lock_strap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access qualification; nothing is accepted while the copy runs.
    assign copying = (state_reg == ceac_pkg::CEAC_ST_COPY);
    assign busy = (state_reg == ceac_pkg::CEAC_ST_BUSY);
    assign acc = req_valid && !copying;
    assign wr_block = nvm_locked_flag || wp_status;
    assign wr_nv_ok = acc && req_write && nv_hit && !busy && !wr_block;
    assign wr_ev_ok = acc && req_write && ev_hit && !busy;
    assign backup_wr = wr_ev_ok && !wr_block;
    // Event record writes pass protect except in broadcast mode, never when locked.
    assign ev_ok = evlog_req && (state_reg == ceac_pkg::CEAC_ST_IDLE) && !nvm_locked_flag
        && !(wp_status && broadcast_mode) && !wr_nv_ok && !backup_wr;
    assign nv_start = wr_nv_ok || backup_wr || ev_ok;
    assign copy_end = copying && (cnt_reg == '0);
    assign write_end = busy && (cnt_reg == '0);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer next state: copy after lockout or restart, then idle, busy per write.
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            ceac_pkg::CEAC_ST_COPY: begin
                if (cnt_reg == '0) begin
                    state_next = ceac_pkg::CEAC_ST_IDLE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            ceac_pkg::CEAC_ST_IDLE: begin
                if (nv_start) begin
                    state_next = ceac_pkg::CEAC_ST_BUSY;
                    cnt_next = ceac_pkg::CNT_W'(WRITE_CYC - 1);
                end
            end
            ceac_pkg::CEAC_ST_BUSY: begin
                if (cnt_reg == '0) begin
                    state_next = ceac_pkg::CEAC_ST_IDLE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            default: begin
                state_next = ceac_pkg::CEAC_ST_COPY;
                cnt_next = ceac_pkg::CNT_W'(COPY_CYC - 1);
            end
        endcase
        if (restart_cmd && !copying) begin
            state_next = ceac_pkg::CEAC_ST_COPY;
            cnt_next = ceac_pkg::CNT_W'(COPY_CYC - 1);
        end
    end

    // Sequencer registers and the status flags derived from the next state.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ceac_pkg::CEAC_ST_COPY;
            cnt_reg <= ceac_pkg::CNT_W'(COPY_CYC - 1);
            nvm_busy <= 1'b0;
            copy_active <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            nvm_busy <= (state_next == ceac_pkg::CEAC_ST_BUSY);
            copy_active <= (state_next == ceac_pkg::CEAC_ST_COPY);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory updates: bus writes, control backup and event record backup.
    always_ff @(posedge clk) begin
        if (wr_nv_ok) begin
            nv_mem[nv_idx] <= req_wdata;
        end else if (backup_wr) begin
            nv_mem[ceac_pkg::EVCTL_IDX] <= req_wdata;
        end else if (ev_ok) begin
            nv_mem[ceac_pkg::EVCTL_IDX] <= op_mem[ceac_pkg::EVCTL_IDX];
        end
    end

    // Operating registers: loaded from memory at copy end, written by the bus otherwise.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < ceac_pkg::OP_N; i++) begin
                op_mem[i] <= ceac_pkg::OP_RESET;
            end
        end else if (copy_end) begin
            for (int i = 0; i < ceac_pkg::OP_N; i++) begin
                op_mem[i] <= nv_mem[i];
            end
        end else if (acc && req_write && op_hit && (!ev_hit || wr_ev_ok)) begin
            op_mem[op_idx] <= req_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Answer one cycle after each request.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_ack <= 1'b0;
            rsp_rdata <= ceac_pkg::UNMAPPED_RD;
        end else begin
            rsp_valid <= req_valid;
            rsp_ack <= 1'b1;
            rsp_rdata <= ceac_pkg::UNMAPPED_RD;
            if (copying) begin
                rsp_ack <= 1'b0;
                rsp_rdata <= ceac_pkg::READ_BLOCKED;
            end else if (req_write) begin
                if (nv_hit) begin
                    rsp_ack <= wr_nv_ok;
                end else if (ev_hit) begin
                    rsp_ack <= wr_ev_ok;
                end
            end else if (nv_hit) begin
                rsp_rdata <= busy ? ceac_pkg::READ_BLOCKED : nv_mem[nv_idx];
            end else if (op_hit) begin
                rsp_rdata <= op_mem[op_idx];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Written flag and alert; a set in the clearing cycle wins.
    always_comb begin
        written_next = nvm_written;
        alert_next = alert_raised;
        if (written_clr) begin
            written_next = 1'b0;
        end
        if (write_end) begin
            written_next = 1'b1;
        end
        if (alert_clr) begin
            alert_next = 1'b0;
        end
        if (write_end && !nvm_written && written_alert_en) begin
            alert_next = 1'b1;
        end
    end

    // Flag registers and the active-low alert line.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nvm_written <= 1'b0;
            alert_raised <= 1'b0;
            alert_n <= 1'b1;
        end else begin
            nvm_written <= written_next;
            alert_raised <= alert_next;
            alert_n <= !alert_next;
        end
    end

endmodule : ceac_top

// [tb/ceac_assertions.sv]
// Checker for the memory access control ports.
// Assumes one core clock and the lockout reset of ceac_top.
`timescale 1ns/1ps
module ceac_checker #(
    parameter int WRITE_CYC = 20
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Access request and answer.
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [7:0] req_addr,
    input wire logic rsp_valid,
    input wire logic rsp_ack,
    input wire logic [7:0] rsp_rdata,
    // Pins, straps and control bits.
    input wire logic wp_pin,
    input wire logic nvm_lock_strap,
    input wire logic restart_cmd,
    input wire logic written_alert_en,
    // Status bits.
    input wire logic nvm_busy,
    input wire logic copy_active,
    input wire logic nvm_written,
    input wire logic alert_raised,
    input wire logic alert_n,
    input wire logic wp_status,
    input wire logic nvm_locked_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic nv_a;
    logic [19:0] busy_cnt_reg;
    // Flags a request aimed at the nonvolatile window.
    assign nv_a = (req_addr >= 8'haa && req_addr <= 8'he0) || (req_addr >= 8'hf0 && req_addr <= 8'hf7);
    // Counts cycles with a write pending.
    always_ff @(posedge clk) busy_cnt_reg <= nvm_busy ? busy_cnt_reg + 20'h1 : 20'h0;
    // A write ends on its own, not by a restart.
    sequence write_end_s;
        $fell(nvm_busy) && !copy_active;
    endsequence
    answer_pair_a: assert property (rsp_valid == $past(req_valid)) else $error("answer count wrong");
    copy_refuse_a: assert property (req_valid && copy_active |=> !rsp_ack && rsp_rdata == 8'hff)
        else $error("access served during copy");
    busy_write_a: assert property (req_valid && req_write && nv_a && nvm_busy && !copy_active |=> !rsp_ack)
        else $error("busy write acked");
    busy_read_a: assert property (req_valid && !req_write && nv_a && nvm_busy && !copy_active
        |=> rsp_ack && rsp_rdata == 8'hff) else $error("busy read not blocked");
    evctl_busy_a: assert property (req_valid && req_write && req_addr == 8'h90 && nvm_busy |=> !rsp_ack)
        else $error("control write acked while busy");
    protect_write_a: assert property (req_valid && req_write && nv_a && (wp_status || nvm_locked_flag)
        |=> !rsp_ack) else $error("protected write acked");
    busy_length_a: assert property (write_end_s |-> int'(busy_cnt_reg) == WRITE_CYC)
        else $error("write time wrong");
    written_set_a: assert property (write_end_s |-> nvm_written) else $error("written flag missing");
    alert_raise_a: assert property (write_end_s ##0 ($past(written_alert_en) && !$past(nvm_written))
        |-> alert_raised && !alert_n) else $error("alert missing");
    alert_pin_a: assert property (alert_n == !alert_raised) else $error("alert pin wrong");
    restart_copy_a: assert property (restart_cmd && !copy_active |=> copy_active) else $error("no copy");
    lock_flag_a: assert property ($past(rst_n) |-> nvm_locked_flag == $past(nvm_lock_strap))
        else $error("lock flag wrong");
    wp_live_a: assert property ($stable(wp_pin) [*5] |-> wp_status == wp_pin) else $error("wp status stale");
endmodule : ceac_checker

bind ceac_top ceac_checker #(.WRITE_CYC(WRITE_CYC)) u_chk (.clk, .rst_n, .req_valid, .req_write, .rsp_valid,
    .rsp_ack, .nvm_busy, .copy_active, .req_addr, .rsp_rdata, .nvm_written, .alert_raised, .alert_n, .wp_pin,
    .wp_status, .nvm_lock_strap, .nvm_locked_flag, .restart_cmd, .written_alert_en);

// [tb/ceac_host_model.sv]
// Host model that issues single-byte register accesses.
// Assumes the block takes a request on the rising edge.
`timescale 1ns/1ps
module ceac_host_model (
    // Clock and pending status.
    input wire logic clk,
    input wire logic nvm_busy,
    // Request towards the block.
    output logic req_valid,
    output logic req_write,
    output logic [7:0] req_addr,
    output logic [7:0] req_wdata
);
    // Idle request lines at time zero.
    initial {req_valid, req_write, req_addr, req_wdata} = 18'h0;

    // Holds a request over one rising edge, then scrambles the released lines.
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
        @(negedge clk);
        {req_valid, req_write, req_addr, req_wdata} = {1'b0, ~w, ~a, ~d};
    endtask : access

    // Counts busy cycles from the current one on, polling at least three cycles and until the memory is free, at most 3000.
    task automatic wait_ready(output int cnt);
        int t;
        cnt = 0;
        for (t = 0; t < 3 || (nvm_busy === 1'b1 && t < 3000); t++) begin
            cnt += int'(nvm_busy === 1'b1);
            @(negedge clk);
        end
    endtask : wait_ready
endmodule : ceac_host_model

// [tb/ceac_top_tb_top.sv]
// Self-checking bench for the memory access control block.
// Assumes the package, the host model and the checker are compiled first.
`timescale 1ns/1ps
module ceac_top_tb_top;
    logic clk, rst_n, req_valid, req_write, rsp_valid, rsp_ack, wp_pin, nvm_lock_strap, broadcast_mode;
    logic restart_cmd, evlog_req, written_alert_en, written_clr, alert_clr, nvm_busy, copy_active;
    logic nvm_written, alert_raised, alert_n, wp_status, nvm_locked_flag;
    logic [7:0] req_addr, req_wdata, rsp_rdata, d0, d1;
    logic [7:0] user_mem[7];
    logic [8:0] exp_q[$];
    int mismatches, total_checks, n;
    int seed = 32'h3cff;

    // Core clock of 4 ns.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ceac_top #(.WRITE_CYC(20), .COPY_CYC(12)) DUT (.clk, .rst_n, .req_valid, .req_write, .req_addr, .req_wdata,
        .rsp_valid, .rsp_ack, .rsp_rdata, .wp_pin, .nvm_lock_strap, .broadcast_mode, .restart_cmd, .evlog_req,
        .written_alert_en, .written_clr, .alert_clr, .nvm_busy, .copy_active, .nvm_written, .alert_raised,
        .alert_n, .wp_status, .nvm_locked_flag);
    ceac_host_model host (.clk, .nvm_busy, .req_valid, .req_write, .req_addr, .req_wdata);

    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Notes the expected answer, then issues the access.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [8:0] e);
        exp_q.push_back(e);
        host.access(w, a, d);
    endtask : acc

    task automatic pulse_ev;
        evlog_req = 1'b1;
        @(negedge clk);
        evlog_req = 1'b0;
        @(negedge clk);
    endtask : pulse_ev

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run

    // Pairs every answer with the oldest noted expectation.
    always @(negedge clk) begin
        if (rsp_valid === 1'b1) check("answer", {rsp_ack, rsp_rdata}, exp_q.size() ? exp_q.pop_front() : 9'bx);
    end

    // Cuts a hang short.
    initial begin
        #40000;
        mismatches++;
        complete_run;
    end

    // Main sequence of scenarios.
    initial begin
        {rst_n, wp_pin, nvm_lock_strap, broadcast_mode, restart_cmd, evlog_req} = 6'h0;
        {written_alert_en, written_clr, alert_clr} = 3'h4;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        acc(1'b0, 8'haa, 8'h00, 9'h0ff);
        acc(1'b1, 8'h0a, 8'h11, 9'h0ff);
        repeat (14) @(negedge clk);
        check("copy_active", {8'h0, copy_active}, 9'h0);
        d0 = 8'($random(seed));
        d1 = 8'($random(seed));
        acc(1'b1, 8'haa, d0, 9'h100);
        host.wait_ready(n);
        check("busy_cycles", 9'(n), 9'd20);
        check("flags", {6'h0, nvm_written, alert_raised, alert_n}, 9'h6);
        {written_clr, alert_clr} = 2'h3;
        @(negedge clk);
        {written_clr, alert_clr} = 2'h0;
        acc(1'b1, 8'hab, d1, 9'h100);
        acc(1'b1, 8'hac, d1, 9'h000);
        acc(1'b0, 8'hab, 8'h00, 9'h1ff);
        acc(1'b1, 8'h90, d1, 9'h000);
        acc(1'b1, 8'h0b, d0, 9'h100);
        acc(1'b0, 8'h0b, 8'h00, {1'b1, d0});
        host.wait_ready(n);
        for (int i = 0; i < 7; i++) begin
            user_mem[i] = 8'($random(seed));
            acc(1'b1, 8'hf1 + 8'(i), user_mem[i], 9'h100);
            host.wait_ready(n);
        end
        for (int i = 0; i < 7; i++) acc(1'b0, 8'hf1 + 8'(i), 8'h00, {1'b1, user_mem[i]});
        wp_pin = 1'b1;
        repeat (6) @(negedge clk);
        check("wp_status", {8'h0, wp_status}, 9'h1);
        acc(1'b1, 8'hac, 8'h55, 9'h000);
        acc(1'b0, 8'hab, 8'h00, {1'b1, d1});
        pulse_ev;
        check("ev_busy", {8'h0, nvm_busy}, 9'h1);
        host.wait_ready(n);
        broadcast_mode = 1'b1;
        pulse_ev;
        check("ev_busy", {8'h0, nvm_busy}, 9'h0);
        {broadcast_mode, wp_pin} = 2'h0;
        repeat (6) @(negedge clk);
        acc(1'b1, 8'h90, d1, 9'h100);
        acc(1'b0, 8'hf0, 8'h00, 9'h1ff);
        host.wait_ready(n);
        restart_cmd = 1'b1;
        @(negedge clk);
        restart_cmd = 1'b0;
        acc(1'b0, 8'h0a, 8'h00, 9'h0ff);
        repeat (14) @(negedge clk);
        acc(1'b0, 8'h0a, 8'h00, {1'b1, d0});
        acc(1'b0, 8'h90, 8'h00, {1'b1, d1});
        nvm_lock_strap = 1'b1;
        @(negedge clk);
        check("locked", {8'h0, nvm_locked_flag}, 9'h1);
        acc(1'b1, 8'had, 8'h12, 9'h000);
        pulse_ev;
        check("lock_busy", {8'h0, nvm_busy}, 9'h0);
        complete_run;
    end
endmodule : ceac_top_tb_top
